// *** arx_pkg.sv ***
// constants and types shared by the receive recovery block
// assumes a 32-bit AXI4-Lite master and one 50 MHz clock
package arx_pkg;
    localparam int ARX_AW = 4;
    localparam int ARX_DW = 32;
    localparam int ARX_BAUD_W = 12;

    // register byte offsets
    localparam logic [ARX_AW-1:0] ARX_OFF_CTRL = 4'h0;
    localparam logic [ARX_AW-1:0] ARX_OFF_BAUD = 4'h4;
    localparam logic [ARX_AW-1:0] ARX_OFF_STAT = 4'h8;
    localparam logic [ARX_AW-1:0] ARX_OFF_DATA = 4'hC;

    // control field positions
    localparam int ARX_CTRL_RXEN = 0;
    localparam int ARX_CTRL_DBL = 1;
    localparam int ARX_CTRL_MPF = 2;
    localparam int ARX_CTRL_CSZ = 3;
    localparam int ARX_CTRL_SBS = 6;

    // status field positions
    localparam int ARX_STAT_RXC = 0;
    localparam int ARX_STAT_FE = 1;
    localparam int ARX_STAT_OVR = 2;
    localparam int ARX_STAT_B8 = 3;
    localparam int ARX_STAT_BUSY = 4;

    // reset values and the nine-bit size code
    localparam logic [2:0] ARX_CSZ_RST = 3'h3;
    localparam logic [2:0] ARX_CSZ_NINE = 3'h7;
    localparam logic [ARX_BAUD_W-1:0] ARX_BAUD_RST = 12'h000;

    // samples per bit, voting window and data bit counts
    localparam logic [4:0] ARX_S_NORM = 5'h10;
    localparam logic [4:0] ARX_S_DBL = 5'h08;
    localparam logic [4:0] ARX_SF_NORM = 5'h08;
    localparam logic [4:0] ARX_SF_DBL = 5'h04;
    localparam logic [3:0] ARX_DBITS_MIN = 4'h5;
    localparam logic [3:0] ARX_DBITS_NINE = 4'h9;
    localparam logic [3:0] ARX_DBITS_DFLT = 4'h8;

    localparam logic [1:0] ARX_RESP_OKAY = 2'h0;
    localparam logic [1:0] ARX_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ARX_IDLE = 2'b00,
        ARX_START = 2'b01,
        ARX_DATA = 2'b10,
        ARX_STOP = 2'b11
    } arx_state_e;
endpackage

// *** arx_rx_checker.sv ***
// bus handshake assertions for the receive recovery block
// assumes bind onto arx_rx_top; sees its ports only
`timescale 1ns/10ps
module arx_rx_checker
    import arx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [ARX_DW-1:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ar_gate;
        s_axi_arready_o != s_axi_rvalid_o;
    endproperty
    a_ar_gate: assert property (p_ar_gate) else $error("arready not inverse of rvalid");
    property p_r_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    property p_r_end;
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
    endproperty
    a_r_end: assert property (p_r_end) else $error("read answer repeated");
    property p_b_lat;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##2 s_axi_bvalid_o;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_b_busy;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while answer pending");
    property p_b_end;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o;
    endproperty
    a_b_end: assert property (p_b_end) else $error("write slot not freed");
    c_slow_read: cover property (s_axi_rvalid_o && !s_axi_rready_i);
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_rx_flag: cover property (s_axi_rvalid_o && s_axi_rready_i && s_axi_rdata_o[0]);
endmodule

// *** arx_rx_top.sv ***
// receive recovery with multidrop filter behind an AXI4-Lite slave
// assumes serial input already synchronous to clk_i, idle high
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module arx_rx_top
    import arx_pkg::*;
#(
    parameter int BAUD_W = ARX_BAUD_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic serial_in_pin_i,
    input wire logic [ARX_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ARX_DW-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ARX_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [ARX_DW-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    typedef struct packed {
        arx_state_e st;
        logic [4:0] smp;
        logic [3:0] nbit;
        logic [8:0] shf;
        logic [1:0] vote;
        logic line_q;
        logic rx_en;
        logic dbl;
        logic mpf;
        logic [2:0] csz;
        logic sbs;
        logic [BAUD_W-1:0] baud;
        logic buf_v;
        logic [8:0] buf_d;
        logic buf_fe;
        logic ovr;
        logic aw_v;
        logic [ARX_AW-1:0] aw_a;
        logic w_v;
        logic [ARX_DW-1:0] w_d;
        logic [3:0] w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [ARX_DW-1:0] rdata;
        logic [1:0] rresp;
    } arx_regs_s;

    arx_regs_s q;
    arx_regs_s next_q;
    logic tick;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // shared size code: one field serves both directions
    function automatic logic [3:0] data_bits(input logic [2:0] csz);
        if (csz == ARX_CSZ_NINE) begin
            data_bits = ARX_DBITS_NINE;
        end else if (!csz[2]) begin
            data_bits = ARX_DBITS_MIN + {2'b00, csz[1:0]};
        end else begin
            data_bits = ARX_DBITS_DFLT;
        end
    endfunction

    function automatic logic is_mapped(input logic [ARX_AW-1:0] a);
        is_mapped = (a == ARX_OFF_CTRL) || (a == ARX_OFF_BAUD) ||
                    (a == ARX_OFF_STAT) || (a == ARX_OFF_DATA);
    endfunction

    arx_sample_tick #(
        .BAUD_W(BAUD_W)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(q.rx_en),
        .divisor_i(q.baud),
        .tick_o(tick)
    );

    logic [4:0] spb;
    logic [4:0] sf;
    logic [4:0] n;
    logic v;
    logic [3:0] nbits;
    logic ftype;
    logic pop;
    logic load;
    logic wr_go;
    logic rd_go;
    logic aw_open;
    logic w_open;

    always_comb begin
        next_q = q;
        // samples per bit follow double speed select
        spb = q.dbl ? ARX_S_DBL : ARX_S_NORM;
        sf = q.dbl ? ARX_SF_DBL : ARX_SF_NORM;
        n = q.smp + 5'h01;
        // majority of the three centre samples
        v = maj3(q.vote[0], q.vote[1], serial_in_pin_i);
        nbits = data_bits(q.csz);
        ftype = 1'b0;
        load = 1'b0;
        rd_go = s_axi_arvalid_i && !q.rvalid;
        pop = rd_go && (s_axi_araddr_i == ARX_OFF_DATA) && q.buf_v;
        wr_go = q.aw_v && q.w_v && !q.bvalid;

        // receive recovery, one step per sample tick
        if (tick) begin
            next_q.line_q = serial_in_pin_i;
            if (q.st == ARX_IDLE) begin
                next_q.smp = '0;
            end else begin
                next_q.smp = n;
            end
            if (q.st != ARX_IDLE && n == sf) begin
                next_q.vote[0] = serial_in_pin_i;
            end
            if (q.st != ARX_IDLE && n == sf + 5'h01) begin
                next_q.vote[1] = serial_in_pin_i;
            end
            case (q.st)
                ARX_IDLE: begin
                    // hunt for a high to low edge
                    if (q.line_q && !serial_in_pin_i) begin
                        next_q.st = ARX_START;
                        next_q.smp = 5'h01;
                        next_q.nbit = '0;
                        next_q.shf = '0;
                    end
                end
                ARX_START: begin
                    // high majority rejects the start as noise
                    if (n == sf + 5'h02 && v) begin
                        next_q.st = ARX_IDLE;
                        next_q.smp = '0;
                    end else if (n == spb) begin
                        // bit period ends after all its samples
                        next_q.st = ARX_DATA;
                        next_q.smp = '0;
                    end
                end
                ARX_DATA: begin
                    if (n == sf + 5'h02) begin
                        next_q.shf[q.nbit] = v;
                    end
                    if (n == spb) begin
                        next_q.smp = '0;
                        next_q.nbit = q.nbit + 4'h1;
                        // after the last data bit comes the stop bit
                        if (q.nbit + 4'h1 == nbits) begin
                            next_q.st = ARX_STOP;
                        end
                    end
                end
                ARX_STOP: begin
                    if (n == sf + 5'h02) begin
                        // ends at the last voting sample, edge may follow
                        next_q.st = ARX_IDLE;
                        next_q.smp = '0;
                        next_q.line_q = 1'b1;
                        // type bit from ninth bit or first stop bit
                        if (q.csz == ARX_CSZ_NINE) begin
                            ftype = q.shf[8];
                        end else begin
                            ftype = v;
                        end
                        // type one is an address frame
                        load = !q.mpf || ftype;
                    end
                end
                default: begin
                    next_q.st = ARX_IDLE;
                end
            endcase
        end

        if (pop) begin
            next_q.buf_v = 1'b0;
            next_q.ovr = 1'b0;
        end
        // new frame wins over a pop in the same cycle
        if (load) begin
            if (q.buf_v && !pop) begin
                next_q.ovr = 1'b1;
            end else begin
                next_q.buf_v = 1'b1;
                next_q.buf_d = q.shf;
                // low stop bit flags a framing error
                next_q.buf_fe = !v;
            end
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid_i && aw_open) begin
            next_q.aw_v = 1'b1;
            next_q.aw_a = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && w_open) begin
            next_q.w_v = 1'b1;
            next_q.w_d = s_axi_wdata_i;
            next_q.w_s = s_axi_wstrb_i;
        end
        if (wr_go) begin
            next_q.aw_v = 1'b0;
            next_q.w_v = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = is_mapped(q.aw_a) ? ARX_RESP_OKAY : ARX_RESP_SLVERR;
            if (q.aw_a == ARX_OFF_CTRL && q.w_s[0]) begin
                next_q.rx_en = q.w_d[ARX_CTRL_RXEN];
                next_q.dbl = q.w_d[ARX_CTRL_DBL];
                // filter enable reaches only receive logic
                next_q.mpf = q.w_d[ARX_CTRL_MPF];
                // single size code for both directions
                next_q.csz = q.w_d[ARX_CTRL_CSZ +: 3];
                next_q.sbs = q.w_d[ARX_CTRL_SBS];
            end
            if (q.aw_a == ARX_OFF_BAUD) begin
                if (q.w_s[0]) begin
                    next_q.baud[7:0] = q.w_d[7:0];
                end
                if (q.w_s[1]) begin
                    next_q.baud[BAUD_W-1:8] = q.w_d[BAUD_W-1:8];
                end
            end
        end
        if (q.bvalid && s_axi_bready_i) begin
            next_q.bvalid = 1'b0;
        end

        // read channel: one read in flight, data port read pops
        if (rd_go) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = is_mapped(s_axi_araddr_i) ? ARX_RESP_OKAY : ARX_RESP_SLVERR;
            next_q.rdata = '0;
            case (s_axi_araddr_i)
                ARX_OFF_CTRL: begin
                    next_q.rdata[ARX_CTRL_RXEN] = q.rx_en;
                    next_q.rdata[ARX_CTRL_DBL] = q.dbl;
                    next_q.rdata[ARX_CTRL_MPF] = q.mpf;
                    next_q.rdata[ARX_CTRL_CSZ +: 3] = q.csz;
                    next_q.rdata[ARX_CTRL_SBS] = q.sbs;
                end
                ARX_OFF_BAUD: begin
                    next_q.rdata[BAUD_W-1:0] = q.baud;
                end
                ARX_OFF_STAT: begin
                    next_q.rdata[ARX_STAT_RXC] = q.buf_v;
                    next_q.rdata[ARX_STAT_FE] = q.buf_v && q.buf_fe;
                    next_q.rdata[ARX_STAT_OVR] = q.ovr;
                    next_q.rdata[ARX_STAT_B8] = q.buf_v && q.buf_d[8];
                    next_q.rdata[ARX_STAT_BUSY] = (q.st != ARX_IDLE);
                end
                ARX_OFF_DATA: begin
                    // bits above the character size arrive as zero
                    next_q.rdata[7:0] = q.buf_v ? q.buf_d[7:0] : 8'h00;
                end
                default: begin
                    next_q.rdata = '0;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready_i) begin
            next_q.rvalid = 1'b0;
        end

        // disabling flushes the buffer and aborts a frame
        if (!q.rx_en) begin
            next_q.st = ARX_IDLE;
            next_q.smp = '0;
            next_q.line_q = 1'b0;
            next_q.buf_v = 1'b0;
            next_q.buf_fe = 1'b0;
            next_q.ovr = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ARX_IDLE;
            q.csz <= ARX_CSZ_RST;
            q.baud <= ARX_BAUD_RST;
        end else begin
            q <= next_q;
        end
    end

    // slots stay shut until the response is taken: one write at a time
    assign aw_open = !q.aw_v && !q.bvalid;
    assign w_open = !q.w_v && !q.bvalid;
    assign s_axi_awready_o = aw_open;
    assign s_axi_wready_o = w_open;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
endmodule

// *** arx_sample_tick.sv ***
// sample-rate divider: one-cycle enable every divisor+1 clocks
// assumes divisor is stable while the receiver is enabled
`timescale 1ns/10ps
module arx_sample_tick
    import arx_pkg::*;
#(
    parameter int BAUD_W = ARX_BAUD_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [BAUD_W-1:0] divisor_i,
    output logic tick_o
);
    typedef struct packed {
        logic [BAUD_W-1:0] cnt;
        logic tick;
    } arx_tick_s;

    arx_tick_s q;
    arx_tick_s next_q;

    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        if (!run_i) begin
            next_q.cnt = divisor_i;
        end else if (q.cnt == '0) begin
            next_q.cnt = divisor_i;
            next_q.tick = 1'b1;
        end else begin
            next_q.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick_o = q.tick;
endmodule

// *** arx_serial_tx_model.sv ***
// far-end serial transmitter, behavioural
// assumes go_i and the frame inputs held until done_o is seen
`timescale 1ns/10ps
module arx_serial_tx_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [11:0] bits_i,
    input wire logic [3:0] count_i,
    input wire logic [7:0] bit_clks_i,
    input wire logic [7:0] last_clks_i,
    output logic line_o,
    output logic done_o
);
    // line idles high between frames, as a pulled-up mark
    initial begin
        line_o = 1'b1;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i && !done_o) begin
                for (int i = 0; i < count_i; i++) begin
                    line_o <= bits_i[i];
                    repeat ((i == count_i - 1) ? last_clks_i : bit_clks_i) @(posedge clk_i);
                end
                line_o <= 1'b1;
                done_o <= 1'b1;
            end else begin
                done_o <= 1'b0;
            end
        end
    end
endmodule

// *** tb_arx_rx_top.sv ***
// self-checking bench for the receive recovery block
// assumes one 50 MHz clock and a transmitter model on the serial pin
`timescale 1ns/10ps
module tb_arx_rx_top;
    import arx_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [8:0] data;
        logic [3:0] nb;
        logic stop;
        logic [7:0] bc;
        logic [3:0] st;
        logic [3:0] mk;
        logic [7:0] dx;
    } arx_row_s;
    // divisor 1: two clocks a sample, 32 a bit, 16 doubled
    localparam arx_row_s ROWS [11] = '{
        '{8'h19, 9'h0A5, 4'h8, 1'b1, 8'h20, 4'h1, 4'h3, 8'hA5},
        '{8'h19, 9'h05A, 4'h8, 1'b0, 8'h20, 4'h3, 4'h3, 8'h5A},
        '{8'h1B, 9'h03C, 4'h8, 1'b1, 8'h10, 4'h1, 4'h3, 8'h3C},
        '{8'h01, 9'h015, 4'h5, 1'b1, 8'h20, 4'h1, 4'h3, 8'h15},
        '{8'h19, 9'h0C3, 4'h8, 1'b1, 8'h1F, 4'h1, 4'h3, 8'hC3},
        '{8'h19, 9'h096, 4'h8, 1'b1, 8'h21, 4'h1, 4'h3, 8'h96},
        '{8'h3D, 9'h1A5, 4'h9, 1'b1, 8'h20, 4'h9, 4'hB, 8'hA5},
        '{8'h39, 9'h0A5, 4'h9, 1'b1, 8'h20, 4'h1, 4'hB, 8'hA5},
        '{8'h3D, 9'h0A5, 4'h9, 1'b1, 8'h20, 4'h0, 4'h1, 8'h00},
        '{8'h1D, 9'h07E, 4'h8, 1'b1, 8'h20, 4'h1, 4'h3, 8'h7E},
        '{8'h1D, 9'h07E, 4'h8, 1'b0, 8'h20, 4'h0, 4'h1, 8'h00}
    };
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic serial_in_pin_i;
    logic [ARX_AW-1:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
    logic [ARX_DW-1:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b1;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [ARX_DW-1:0] s_axi_rdata_o;
    logic go = 1'b0;
    logic done;
    logic [11:0] bits = 12'h0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] bclk = 8'h0, lclk = 8'h0;
    int miscompares = 0;
    int checks_done = 0;

    always #10 clk_i = ~clk_i;

    arx_rx_top #(.BAUD_W(ARX_BAUD_W)) u_dut (.clk_i, .rst_i, .serial_in_pin_i,
        .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i);
    arx_serial_tx_model u_far (.clk_i, .go_i(go), .bits_i(bits), .count_i(cnt),
        .bit_clks_i(bclk), .last_clks_i(lclk), .line_o(serial_in_pin_i), .done_o(done));

    task automatic stop_test(input bit hung);
        if (hung) miscompares++;
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // response ready stays high, so each answer is taken on the edge it shows
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_i);
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o === 1'b1) begin
                chk("bresp", {30'h0, s_axi_bresp_o}, 32'h0);
                return;
            end
        end
        stop_test(1'b1);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_i);
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1) begin
                d = s_axi_rdata_o;
                chk("rresp", {30'h0, s_axi_rresp_o}, 32'h0);
                return;
            end
        end
        stop_test(1'b1);
    endtask

    // leading edge keeps go from being set twice in one step
    task automatic send(input logic [11:0] w, input logic [3:0] c, input logic [7:0] b,
                        input logic [7:0] l);
        @(posedge clk_i);
        bits <= w;
        cnt <= c;
        bclk <= b;
        lclk <= l;
        go <= 1'b1;
        for (int n = 0; n < 600; n++) begin
            @(posedge clk_i);
            if (done === 1'b1) begin
                go <= 1'b0;
                return;
            end
        end
        stop_test(1'b1);
    endtask

    // ninth bit as type, two stop bits
    function automatic logic [11:0] frm(logic [8:0] d, logic [3:0] nb, logic sb);
        logic [11:0] w;
        w = {2'h0, d & ~(9'h1FF << nb), 1'b0};
        w[nb + 4'h1] = sb;
        w[nb + 4'h2] = 1'b1;
        return w;
    endfunction

    initial begin
        logic [31:0] v;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ARX_OFF_CTRL, v);
        chk("ctrl", v, 32'h18);
        rd(ARX_OFF_BAUD, v);
        chk("baud", v, 32'h0);
        wr(ARX_OFF_STAT, 32'h1F);
        rd(ARX_OFF_STAT, v);
        chk("status", v, 32'h0);
        wr(ARX_OFF_BAUD, 32'h1);
        rd(ARX_OFF_BAUD, v);
        chk("baud", v, 32'h1);
        foreach (ROWS[i]) begin
            wr(ARX_OFF_CTRL, {24'h0, ROWS[i].ctrl});
            send(frm(ROWS[i].data, ROWS[i].nb, ROWS[i].stop), ROWS[i].nb + 4'h3,
                 ROWS[i].bc, ROWS[i].bc);
            rd(ARX_OFF_STAT, v);
            chk("status", v & {28'h0, ROWS[i].mk}, {28'h0, ROWS[i].st});
            if (ROWS[i].st[0]) begin
                rd(ARX_OFF_DATA, v);
                chk("data", v, {24'h0, ROWS[i].dx});
            end
        end
        wr(ARX_OFF_CTRL, 32'h19);
        // stop cut short just past its voting samples
        fork
            begin
                send(frm(9'h081, 4'h8, 1'b1), 4'hA, 8'h20, 8'h16);
                send(frm(9'h042, 4'h8, 1'b1), 4'hB, 8'h20, 8'h20);
            end
            begin
                v = 32'h0;
                for (int n = 0; n < 250 && v[0] !== 1'b1; n++) rd(ARX_OFF_STAT, v);
                rd(ARX_OFF_DATA, v);
                chk("first", v, 32'h81);
            end
        join
        rd(ARX_OFF_STAT, v);
        chk("status", v & 32'h7, 32'h1);
        rd(ARX_OFF_DATA, v);
        chk("second", v, 32'h42);
        // short low pulse, then a wait longer than the start check
        send(12'h0, 4'h1, 8'h06, 8'h06);
        repeat (40) @(posedge clk_i);
        send(frm(9'h055, 4'h8, 1'b1), 4'hB, 8'h20, 8'h20);
        rd(ARX_OFF_STAT, v);
        chk("status", v & 32'h7, 32'h1);
        rd(ARX_OFF_DATA, v);
        chk("data", v, 32'h55);
        // reset with a frame waiting must empty the buffer
        send(frm(9'h033, 4'h8, 1'b1), 4'hB, 8'h20, 8'h20);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ARX_OFF_STAT, v);
        chk("status", v, 32'h0);
        rd(ARX_OFF_CTRL, v);
        chk("ctrl", v, 32'h18);
        stop_test(1'b0);
    end
endmodule

bind arx_rx_top arx_rx_checker u_chk (.clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i);
